// ---- dv/test_fsc_regs.sv ----
// test_fsc_regs: self-checking bench for the float status and condition flag bank.
// assumes fsc_pkg is compiled first; the bench drives all inputs on the falling edge.
`timescale 1ns/1ps

module test_fsc_regs;
    logic                    sys_clk;
    logic                    reset;
    fsc_pkg::fsc_cmd_s       cmd;
    fsc_pkg::fsc_cmd_s       c;
    fsc_pkg::fsc_fp_event_s  fp_event;
    fsc_pkg::fsc_int_event_s int_event;
    logic [31:0]             integer_exception_reg;
    logic [4:0]              test_bit;
    logic                    test_value;
    logic [31:0]             float_status_control;
    logic [31:0]             condition_flags;
    fsc_pkg::fsc_enables_s   trap_enables;
    logic                    relaxed_ieee_mode;
    fsc_pkg::fsc_round_e     round_select;
    int                      n_errors = 0;
    int                      checked = 0;

    fsc_regs fsc_regs_inst (
        .sys_clk               (sys_clk),
        .reset                 (reset),
        .cmd                   (cmd),
        .fp_event              (fp_event),
        .int_event             (int_event),
        .integer_exception_reg (integer_exception_reg),
        .test_bit              (test_bit),
        .test_value            (test_value),
        .float_status_control  (float_status_control),
        .condition_flags       (condition_flags),
        .trap_enables          (trap_enables),
        .relaxed_ieee_mode     (relaxed_ieee_mode),
        .round_select          (round_select)
    );

    // 50 MHz core clock
    initial sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one instruction for one cycle, then idle; returns with outputs settled
    task automatic exec(input fsc_pkg::fsc_cmd_s x);
        @(negedge sys_clk);
        cmd = x;
        @(negedge sys_clk);
        cmd = '0;
    endtask

    task automatic fp_pulse(input fsc_pkg::fsc_fp_event_s e);
        @(negedge sys_clk);
        fp_event = e;
        @(negedge sys_clk);
        fp_event = '0;
    endtask

    // set or clear one float status bit, msb-first numbering
    task automatic fs_bit(input logic set, input logic [4:0] b);
        c = '0;
        c.op = set ? fsc_pkg::FSC_OP_SET_FSB : fsc_pkg::FSC_OP_CLR_FSB;
        c.bit_d = b;
        exec(c);
    endtask

    task automatic t_masked_move_and_test();
        c = '0;
        c.op = fsc_pkg::FSC_OP_MOVE_CF;
        c.mask = 8'hFF;
        c.operand_a = 32'h1234_5678;
        exec(c);
        check(condition_flags, 32'h1234_5678);
        c.mask = 8'h01;
        c.operand_a = 32'hABCD_EF01;
        exec(c);
        check(condition_flags, 32'hA234_5678);
        for (int i = 0; i < 32; i++) begin
            test_bit = 5'(i);
            #1;
            check(32'(test_value), (32'hA234_5678 >> (31 - i)) & 32'h1);
            @(negedge sys_clk);
        end
        c = '0;
        c.op = fsc_pkg::FSC_OP_COPY_CF;
        c.src_field = 3'h2;
        c.dst_field = 3'h7;
        exec(c);
        check(condition_flags, 32'hA234_5673);
        integer_exception_reg = 32'hA000_0000;
        c.op = fsc_pkg::FSC_OP_IX_TO_CF;
        c.dst_field = 3'h2;
        exec(c);
        check(condition_flags, 32'hA2A4_5673);
    endtask

    task automatic t_logic();
        logic [2:0] f;
        logic       exp;
        for (int i = 0; i < 8; i++) begin
            f = 3'(i);
            c = '0;
            c.op = fsc_pkg::FSC_OP_MOVE_CF;
            c.mask = 8'hFF;
            c.operand_a = 32'h4000_0000;
            exec(c);
            c.op = fsc_pkg::FSC_OP_CF_LOGIC;
            c.bit_a = 5'h00;
            c.bit_b = 5'h01;
            c.bit_d = 5'h1F;
            c.logic_fn = fsc_pkg::fsc_logic_e'(f);
            exec(c);
            // bit a is 0, bit b is 1
            exp = (f == 3'h1 || f == 3'h2 || f == 3'h3) ? 1'b1 : 1'b0;
            check(condition_flags, {2'b01, 29'h0, exp});
        end
    endtask

    task automatic t_compare();
        integer_exception_reg = 32'h8000_0000;
        c = '0;
        c.op = fsc_pkg::FSC_OP_COMPARE;
        c.dst_field = 3'h3;
        c.operand_a = 32'hFFFF_FFFF;
        c.operand_b = 32'h0000_0001;
        c.cmp_signed = 1'b1;
        exec(c);
        check(32'(condition_flags[19:16]), 32'h9);
        c.cmp_signed = 1'b0;
        exec(c);
        check(32'(condition_flags[19:16]), 32'h5);
        c.cmp_float = 1'b1;
        c.float_outcome = 4'h1;
        c.dst_field = 3'h6;
        exec(c);
        check(32'(condition_flags[7:4]), 32'h1);
    endtask

    task automatic t_int_record();
        logic [31:0] r[3] = '{32'h8000_0000, 32'h0000_0001, 32'h0000_0000};
        for (int i = 0; i < 3; i++) begin
            @(negedge sys_clk);
            int_event = '{1'b1, r[i], i[0]};
            @(negedge sys_clk);
            int_event = '0;
            check(32'(condition_flags[31:28]), 32'({4'b1000 >> i} | 4'(i[0])));
        end
    endtask

    task automatic t_fs_controls();
        logic [4:0] en;
        en = 5'h00;
        for (int i = 0; i < 5; i++) begin
            fs_bit(1'b1, 5'(24 + i));
            en = en | (5'b10000 >> i);
            check(32'(trap_enables), 32'(en));
        end
        fs_bit(1'b1, 5'd29);
        check(32'(relaxed_ieee_mode), 32'h1);
        fs_bit(1'b0, 5'd29);
        check(32'(relaxed_ieee_mode), 32'h0);
        for (int r = 0; r < 4; r++) begin
            fs_bit(r[1], 5'd30);
            fs_bit(r[0], 5'd31);
            check(32'(round_select), 32'(r));
        end
    endtask

    task automatic t_sticky_and_class();
        fsc_pkg::fsc_class_e cls[9] = '{fsc_pkg::FSC_CLS_QNAN, fsc_pkg::FSC_CLS_NEG_INF,
            fsc_pkg::FSC_CLS_NEG_NORM, fsc_pkg::FSC_CLS_NEG_DEN, fsc_pkg::FSC_CLS_NEG_ZERO,
            fsc_pkg::FSC_CLS_POS_ZERO, fsc_pkg::FSC_CLS_POS_DEN, fsc_pkg::FSC_CLS_POS_NORM,
            fsc_pkg::FSC_CLS_POS_INF};
        fp_pulse('{1'b1, 1'b0, 1'b0, fsc_pkg::FSC_CLS_QNAN, 1'b0});
        repeat (3) @(negedge sys_clk);
        check(32'(float_status_control[11:8]), 32'h2);
        fp_pulse('{1'b0, 1'b1, 1'b0, fsc_pkg::FSC_CLS_QNAN, 1'b0});
        check(32'(float_status_control[11:8]), 32'h3);
        fs_bit(1'b1, 5'd21);
        check(32'(float_status_control[11:8]), 32'h7);
        c = '0;
        c.op = fsc_pkg::FSC_OP_FS_TO_CF;
        c.src_field = 3'h5;
        c.dst_field = 3'h4;
        exec(c);
        check(32'(condition_flags[15:12]), 32'h7);
        check(32'(float_status_control[11:8]), 32'h0);
        // masked group move: only group 5 may take the operand
        c = '0;
        c.op = fsc_pkg::FSC_OP_MOVE_FS;
        c.mask = 8'h20;
        c.operand_a = 32'hFFFF_F4FF;
        exec(c);
        check(32'(float_status_control[11:8]), 32'h4);
        check(32'(trap_enables), 32'h1F);
        for (int i = 0; i < 9; i++) begin
            fp_pulse('{1'b0, 1'b0, 1'b1, cls[i], 1'b0});
            check(32'(float_status_control[16:12]), 32'(cls[i]));
        end
        // give the top four status bits a known non-zero pattern before recording
        fs_bit(1'b1, 5'd0);
        fs_bit(1'b1, 5'd2);
        check(32'(float_status_control[31:28]), 32'hA);
        fp_pulse('{1'b0, 1'b0, 1'b0, fsc_pkg::FSC_CLS_QNAN, 1'b1});
        check(32'(condition_flags[27:24]), 32'hA);
    endtask

    // watchdog, far beyond the under two hundred cycles the tests need
    initial begin
        #200000;
        n_errors++;
        summarize();
    end

    // reset, then the scenarios in turn
    initial begin
        reset = 1'b1;
        cmd = '0;
        c = '0;
        fp_event = '0;
        int_event = '0;
        integer_exception_reg = 32'h0000_0000;
        test_bit = 5'h00;
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        check(float_status_control, 32'h0000_0000);
        check(condition_flags, 32'h0000_0000);
        t_masked_move_and_test();
        t_logic();
        t_compare();
        t_int_record();
        t_fs_controls();
        t_sticky_and_class();
        summarize();
    end
endmodule

// ---- verilog/fsc_pkg.sv ----
// fsc_pkg: constants, enums and structs for the float status and condition flag bank.
// assumes one core clock; bit numbers below are vector indices (msb-first bit k is 31-k).
package fsc_pkg;

    localparam int unsigned FSC_WIDTH      = 32;
    localparam int unsigned FSC_FIELDS     = 8;
    localparam int unsigned FSC_FIELD_W    = 4;
    // float status bit positions, vector index = 31 - documented bit
    localparam int unsigned FSC_RSVD_BIT   = 11;  // documented bit 20, reads zero
    localparam int unsigned FSC_SOFT_BIT   = 10;  // software_invalid_flag, bit 21
    localparam int unsigned FSC_ROOT_BIT   = 9;   // bad_root_flag, bit 22
    localparam int unsigned FSC_CONV_BIT   = 8;   // bad_convert_flag, bit 23
    localparam int unsigned FSC_EN_HI      = 7;   // enables, bits 24..28
    localparam int unsigned FSC_EN_LO      = 3;
    localparam int unsigned FSC_NI_BIT     = 2;   // relaxed_ieee_mode, bit 29
    localparam int unsigned FSC_RND_HI     = 1;   // round_select, bits 30..31
    localparam int unsigned FSC_CLS_HI     = 16;  // result_class_flags, bits 15..19
    localparam int unsigned FSC_CLS_LO     = 12;
    // sticky exception bits that a field move to the flags clears (bits 0, 3..12, 21..23)
    localparam logic [31:0] FSC_STICKY_MASK = 32'h9FF8_0700;
    localparam logic [31:0] FSC_RESET_VAL   = 32'h0000_0000;
    localparam logic [31:0] CF_RESET_VAL    = 32'h0000_0000;

    typedef enum logic [1:0] {
        FSC_RND_NEAREST = 2'b00,
        FSC_RND_ZERO    = 2'b01,
        FSC_RND_POS_INF = 2'b10,
        FSC_RND_NEG_INF = 2'b11
    } fsc_round_e;

    typedef enum logic [4:0] {
        FSC_CLS_QNAN     = 5'b10001,
        FSC_CLS_NEG_INF  = 5'b01001,
        FSC_CLS_NEG_NORM = 5'b01000,
        FSC_CLS_NEG_DEN  = 5'b11000,
        FSC_CLS_NEG_ZERO = 5'b10010,
        FSC_CLS_POS_ZERO = 5'b00010,
        FSC_CLS_POS_DEN  = 5'b10100,
        FSC_CLS_POS_NORM = 5'b00100,
        FSC_CLS_POS_INF  = 5'b00101
    } fsc_class_e;

    typedef enum logic [3:0] {
        FSC_OP_NONE    = 4'h0,
        FSC_OP_MOVE_CF = 4'h1,  // masked move general_register -> condition_flags
        FSC_OP_COPY_CF = 4'h2,  // field to field copy
        FSC_OP_FS_TO_CF = 4'h3, // float status group -> field
        FSC_OP_IX_TO_CF = 4'h4, // integer_exception_reg -> field
        FSC_OP_CF_LOGIC = 4'h5, // bitwise logic on flag bits
        FSC_OP_COMPARE = 4'h6,  // compare into named field
        FSC_OP_MOVE_FS = 4'h7,  // masked move of float status groups
        FSC_OP_CLR_FSB = 4'h8,  // clear_float_status_bit
        FSC_OP_SET_FSB = 4'h9   // set_float_status_bit
    } fsc_op_e;

    typedef enum logic [2:0] {
        FSC_LG_AND  = 3'h0,
        FSC_LG_OR   = 3'h1,
        FSC_LG_XOR  = 3'h2,
        FSC_LG_NAND = 3'h3,
        FSC_LG_NOR  = 3'h4,
        FSC_LG_EQV  = 3'h5,
        FSC_LG_ANDC = 3'h6,
        FSC_LG_ORC  = 3'h7
    } fsc_logic_e;

    typedef struct packed {
        fsc_op_e     op;
        logic [2:0]  dst_field;
        logic [2:0]  src_field;
        logic [7:0]  mask;        // bit n selects field or group n
        logic [4:0]  bit_a;
        logic [4:0]  bit_b;
        logic [4:0]  bit_d;       // target bit, also the bit of set/clear moves
        fsc_logic_e  logic_fn;
        logic [31:0] operand_a;
        logic [31:0] operand_b;
        logic        cmp_signed;
        logic        cmp_float;
        logic [3:0]  float_outcome; // lt, gt, eq, unordered from the float unit
    } fsc_cmd_s;

    typedef struct packed {
        logic        bad_root;
        logic        bad_convert;
        logic        class_valid;
        fsc_class_e  result_class;
        logic        record;
    } fsc_fp_event_s;

    typedef struct packed {
        logic        record;
        logic [31:0] result;
        logic        summary_overflow;
    } fsc_int_event_s;

    typedef struct packed {
        logic invalid_op;
        logic overflow;
        logic underflow;
        logic zero_divide;
        logic inexact;
    } fsc_enables_s;

    typedef struct packed {
        logic [31:0] float_status_control;
        logic [31:0] condition_flags;
    } fsc_state_s;

endpackage

// ---- verilog/fsc_regs.sv ----
// fsc_regs: float status upper bits and the eight-field condition flag register.
// assumes one instruction per cycle on cmd; fp and integer side effects arrive alongside.
//
// Summary of operation
// R1 - software invalid flag changes only through the four float status moves; sticky
// R2 - invalid square root operand sets the sticky bad root flag
// R3 - invalid float to integer conversion sets the sticky bad convert flag
// R4 - five enables at bits 24..28: invalid, overflow, underflow, zero divide, inexact
// R5 - store denormalization does not depend on the underflow enable
// R6 - bit 29 selects relaxed non-IEEE operation
// R7 - bits 30..31 pick rounding: nearest, zero, plus infinity, minus infinity
// R8 - result class flags use the nine fixed five-bit encodings
// R9 - flag register is 32 bits, eight 4-bit fields numbered from the top
// R10 - masked move writes selected fields from a general register, others kept
// R11 - field copy moves one field into another
// R12 - a float status group can load any flag field
// R13 - the integer exception register can load any flag field
// R14 - logic instructions combine single flag bits into a named bit
// R15 - integer operations with recording update field 0
// R16 - float operations with recording update field 1
// R17 - compares write their outcome into the named field
// R18 - any single flag bit can be tested for branching
// R19 - field 0 gets negative, positive, zero of result and summary overflow
// R20 - field 1 copies the top four float status bits
// R21 - hardware only sets sticky flags; only float status moves clear them
`timescale 1ns/1ps

module fsc_regs #(
    parameter bit CLEAR_ON_RESET = 1'b1
) (
    input  wire logic                    sys_clk,
    input  wire logic                    reset,
    input  wire fsc_pkg::fsc_cmd_s       cmd,
    input  wire fsc_pkg::fsc_fp_event_s  fp_event,
    input  wire fsc_pkg::fsc_int_event_s int_event,
    input  wire logic [31:0]             integer_exception_reg,
    input  wire logic [4:0]              test_bit,
    output logic                         test_value,
    output logic [31:0]                  float_status_control,
    output logic [31:0]                  condition_flags,
    output fsc_pkg::fsc_enables_s        trap_enables,
    output logic                         relaxed_ieee_mode,
    output fsc_pkg::fsc_round_e          round_select
);

    fsc_pkg::fsc_state_s state;
    fsc_pkg::fsc_state_s next_state;
    logic [31:0]         move_cf_val;
    logic [31:0]         move_fs_val;

    // field n sits at vector bits 31-4n down to 28-4n
    function automatic logic [3:0] get_field(input logic [31:0] v, input logic [2:0] n);
        logic [4:0] top;
        top = 5'(5'd31 - {n, 2'b00});
        return v[top -: 4];
    endfunction

    function automatic logic [31:0] put_field(input logic [31:0] v, input logic [2:0] n,
                                              input logic [3:0] f);
        logic [31:0] r;
        logic [4:0]  top;
        r = v;
        top = 5'(5'd31 - {n, 2'b00});
        r[top -: 4] = f;
        return r;
    endfunction

    // per-field selection for the two masked moves
    for (genvar i = 0; i < fsc_pkg::FSC_FIELDS; i++) begin : g_field
        localparam int unsigned HI = 31 - 4 * i;
        assign move_cf_val[HI -: 4] = cmd.mask[i] ? cmd.operand_a[HI -: 4]
                                                  : state.condition_flags[HI -: 4]; // R10
        assign move_fs_val[HI -: 4] = cmd.mask[i] ? cmd.operand_a[HI -: 4]
                                                  : state.float_status_control[HI -: 4]; // R1
    end

    // next state: instruction first, then hardware side effects (sets win)
    always_comb begin
        logic       a;
        logic       b;
        logic       r;
        logic       lt;
        logic       gt;
        logic [3:0] grp;
        logic [3:0] outcome;
        next_state = state;
        a = state.condition_flags[5'(5'd31 - cmd.bit_a)];
        b = state.condition_flags[5'(5'd31 - cmd.bit_b)];
        r = 1'b0;
        lt = cmd.cmp_signed ? ($signed(cmd.operand_a) < $signed(cmd.operand_b))
                            : (cmd.operand_a < cmd.operand_b);
        gt = cmd.cmp_signed ? ($signed(cmd.operand_a) > $signed(cmd.operand_b))
                            : (cmd.operand_a > cmd.operand_b);
        grp = get_field(state.float_status_control, cmd.src_field);
        outcome = cmd.cmp_float ? cmd.float_outcome
                                : {lt, gt, cmd.operand_a == cmd.operand_b,
                                   integer_exception_reg[31]};
        case (cmd.op)
            fsc_pkg::FSC_OP_MOVE_CF: begin
                next_state.condition_flags = move_cf_val; // R10
            end
            fsc_pkg::FSC_OP_COPY_CF: begin
                next_state.condition_flags = put_field(state.condition_flags, cmd.dst_field,
                    get_field(state.condition_flags, cmd.src_field)); // R11
            end
            fsc_pkg::FSC_OP_FS_TO_CF: begin
                next_state.condition_flags = put_field(state.condition_flags, cmd.dst_field,
                    grp); // R12
                // copied sticky bits are cleared by the move
                next_state.float_status_control = put_field(state.float_status_control,
                    cmd.src_field,
                    grp & ~get_field(fsc_pkg::FSC_STICKY_MASK, cmd.src_field)); // R1 R21
            end
            fsc_pkg::FSC_OP_IX_TO_CF: begin
                next_state.condition_flags = put_field(state.condition_flags, cmd.dst_field,
                    integer_exception_reg[31:28]); // R13
            end
            fsc_pkg::FSC_OP_CF_LOGIC: begin
                case (cmd.logic_fn)
                    fsc_pkg::FSC_LG_AND:  r = a & b;
                    fsc_pkg::FSC_LG_OR:   r = a | b;
                    fsc_pkg::FSC_LG_XOR:  r = a ^ b;
                    fsc_pkg::FSC_LG_NAND: r = ~(a & b);
                    fsc_pkg::FSC_LG_NOR:  r = ~(a | b);
                    fsc_pkg::FSC_LG_EQV:  r = ~(a ^ b);
                    fsc_pkg::FSC_LG_ANDC: r = a & ~b;
                    fsc_pkg::FSC_LG_ORC:  r = a | ~b;
                    default:              r = 1'b0;
                endcase
                next_state.condition_flags[5'(5'd31 - cmd.bit_d)] = r; // R14
            end
            fsc_pkg::FSC_OP_COMPARE: begin
                next_state.condition_flags = put_field(state.condition_flags, cmd.dst_field,
                    outcome); // R17
            end
            fsc_pkg::FSC_OP_MOVE_FS: begin
                next_state.float_status_control = move_fs_val; // R1
            end
            fsc_pkg::FSC_OP_CLR_FSB: begin
                next_state.float_status_control[5'(5'd31 - cmd.bit_d)] = 1'b0; // R1
            end
            fsc_pkg::FSC_OP_SET_FSB: begin
                next_state.float_status_control[5'(5'd31 - cmd.bit_d)] = 1'b1; // R1
            end
            default: begin
                next_state = state;
            end
        endcase
        // hardware events only ever set the sticky flags
        if (fp_event.bad_root) begin
            next_state.float_status_control[fsc_pkg::FSC_ROOT_BIT] = 1'b1; // R2 R21
        end
        if (fp_event.bad_convert) begin
            next_state.float_status_control[fsc_pkg::FSC_CONV_BIT] = 1'b1; // R3 R21
        end
        if (fp_event.class_valid) begin
            next_state.float_status_control[fsc_pkg::FSC_CLS_HI:fsc_pkg::FSC_CLS_LO] =
                fp_event.result_class; // R8
        end
        next_state.float_status_control[fsc_pkg::FSC_RSVD_BIT] = 1'b0;
        // implicit recording into fields 0 and 1
        if (int_event.record) begin
            next_state.condition_flags[31:28] = {int_event.result[31],
                !int_event.result[31] && (int_event.result != 32'h0000_0000),
                int_event.result == 32'h0000_0000, int_event.summary_overflow}; // R15 R19
        end
        if (fp_event.record) begin
            next_state.condition_flags[27:24] =
                next_state.float_status_control[31:28]; // R16 R20
        end
    end

    // state register; architecturally unchanged at reset unless clearing is chosen
    always_ff @(posedge sys_clk) begin
        if (reset && CLEAR_ON_RESET) begin
            state.float_status_control <= fsc_pkg::FSC_RESET_VAL;
            state.condition_flags      <= fsc_pkg::CF_RESET_VAL;
        end else begin
            state <= next_state;
        end
    end

    // register views and decoded controls
    assign float_status_control = state.float_status_control;
    assign condition_flags      = state.condition_flags; // R9
    assign trap_enables         = state.float_status_control[fsc_pkg::FSC_EN_HI:
                                                             fsc_pkg::FSC_EN_LO]; // R4
    // no denormalization control is derived from the underflow enable
    assign relaxed_ieee_mode    = state.float_status_control[fsc_pkg::FSC_NI_BIT]; // R6 R5
    assign round_select         = fsc_pkg::fsc_round_e'(
                                  state.float_status_control[fsc_pkg::FSC_RND_HI:0]); // R7
    assign test_value           = state.condition_flags[5'(5'd31 - test_bit)]; // R18

    // checks
    AST_SOFT_ONLY_MOVES: assert property (@(posedge sys_clk) disable iff (reset) // R1
        !(cmd.op inside {fsc_pkg::FSC_OP_FS_TO_CF, fsc_pkg::FSC_OP_MOVE_FS,
                         fsc_pkg::FSC_OP_CLR_FSB, fsc_pkg::FSC_OP_SET_FSB})
        |=> $stable(state.float_status_control[fsc_pkg::FSC_SOFT_BIT]))
        else $error("software invalid flag changed without a float status move");
    AST_ROOT_SET: assert property (@(posedge sys_clk) disable iff (reset) // R2
        fp_event.bad_root |=> float_status_control[fsc_pkg::FSC_ROOT_BIT])
        else $error("bad root flag not set after invalid root");
    AST_CONV_SET: assert property (@(posedge sys_clk) disable iff (reset) // R3
        fp_event.bad_convert |=> float_status_control[fsc_pkg::FSC_CONV_BIT])
        else $error("bad convert flag not set after invalid conversion");
    AST_STICKY_HOLD: assert property (@(posedge sys_clk) disable iff (reset) // R21
        $fell(float_status_control[fsc_pkg::FSC_ROOT_BIT])
        |-> $past(cmd.op) inside {fsc_pkg::FSC_OP_FS_TO_CF, fsc_pkg::FSC_OP_MOVE_FS,
                                  fsc_pkg::FSC_OP_CLR_FSB})
        else $error("bad root flag cleared by hardware");
    AST_MASK_KEEP: assert property (@(posedge sys_clk) disable iff (reset) // R10
        cmd.op == fsc_pkg::FSC_OP_MOVE_CF && !cmd.mask[7] |=> $stable(condition_flags[3:0]))
        else $error("unselected field changed by masked move");
    AST_FIELD_COPY: assert property (@(posedge sys_clk) disable iff (reset) // R11
        cmd.op == fsc_pkg::FSC_OP_COPY_CF && cmd.dst_field == 3'h7 && cmd.src_field == 3'h2
        |=> condition_flags[3:0] == $past(condition_flags[23:20]))
        else $error("field copy wrong");
    AST_INT_RECORD: assert property (@(posedge sys_clk) disable iff (reset) // R19
        int_event.record && cmd.op == fsc_pkg::FSC_OP_NONE
        |=> condition_flags[31:28] == {$past(int_event.result[31]),
            !$past(int_event.result[31]) && $past(int_event.result) != 32'h0000_0000,
            $past(int_event.result) == 32'h0000_0000, $past(int_event.summary_overflow)})
        else $error("field 0 does not reflect the integer result");
    AST_FP_RECORD: assert property (@(posedge sys_clk) disable iff (reset) // R20
        fp_event.record && !fp_event.class_valid && cmd.op == fsc_pkg::FSC_OP_NONE
        |=> condition_flags[27:24] == float_status_control[31:28])
        else $error("field 1 does not copy the top float status bits");
    AST_ROUND_VIEW: assert property (@(posedge sys_clk) disable iff (reset) // R7
        cmd.op == fsc_pkg::FSC_OP_SET_FSB && cmd.bit_d == 5'h1F
        |=> round_select[0])
        else $error("rounding field does not follow bit 31");
    AST_TEST_BIT: assert property (@(posedge sys_clk) disable iff (reset) // R18
        test_bit == 5'h00 |-> test_value == condition_flags[31])
        else $error("bit test does not see flag bit 0");

endmodule
